// ==== ext_port_model.sv ====
/*
 * behavioural model of the external dynamic control port.
 * assumes the bench raises fire for one clk cycle with idx valid.
 */
`timescale 1ns/100ps
module ext_port_model (
    // bench side
    input  wire logic        clk,
    input  wire logic        fire,
    input  wire logic [18:0] idx,
    // pins towards the decoder
    output logic             ext_sel_valid = 1'b0,
    output logic [18:0]      ext_sel_index = 19'h00000
);
    int hold_cnt = 0;  // cycles the request still stands

    // request stands eight cycles, long enough for the synchroniser
    always @(posedge clk) begin
        if (fire) begin
            hold_cnt      <= 8;
            ext_sel_index <= idx;  // index stable while valid is high
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            ext_sel_index <= ~ext_sel_index;  // released: index toggles between the last value and its inverse
        end
        ext_sel_valid <= fire || (hold_cnt > 1);
    end
endmodule : ext_port_model

// ==== seq_entry_pkg.sv ====
/*
 * constants, types and the register map of the sequence entry decoder.
 * assumes one 200 MHz clock and a 32-bit apb slave with word-aligned registers.
 */
package seq_entry_pkg;

    // apb byte offsets
    localparam logic [7:0] OFS_WORD0    = 8'h00;  // entry words 0..5 at 0x00..0x14
    localparam logic [7:0] OFS_CTRL     = 8'h18;  // submit, mode, dynamic, ext off
    localparam logic [7:0] OFS_STATUS   = 8'h1C;  // busy, invalid, kind
    localparam logic [7:0] OFS_HOST_SEL = 8'h20;  // host dynamic selection command
    localparam logic [7:0] OFS_SEL_NOW  = 8'h24;  // last accepted selection
    localparam logic [7:0] OFS_REMAIN   = 8'h28;  // idle granules still to run
    localparam int         NUM_WORDS    = 6;      // words per entry

    // control register fields
    localparam int CTRL_SUBMIT_BIT  = 0;
    localparam int CTRL_MODE_LSB    = 1;
    localparam int CTRL_DYN_BIT     = 4;
    localparam int CTRL_EXTOFF_BIT  = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status register fields
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_INVALID_BIT = 1;
    localparam int STAT_KIND_LSB    = 2;

    // entry word fields
    localparam int          CMD_FLAG_BIT  = 31;
    localparam logic [15:0] CODE_IDLE     = 16'h0000;
    localparam logic [15:0] CODE_CONFIG   = 16'h0001;
    localparam logic [31:0] END_TO_SEGEND = 32'hFFFF_FFFF;
    localparam int          SEG_ID_W      = 19;

    // idle delay minimums in delay units
    localparam logic [31:0] MIN_SPEED     = 32'd640;  // 10*64
    localparam logic [31:0] MIN_PRECISION = 32'd480;  // 10*48
    localparam logic [31:0] MIN_INTERP    = 32'd240;  // 10*24

    // output modes
    typedef enum logic [2:0] {
        direct_high_speed_output     = 3'b000,
        direct_high_precision_output = 3'b001,
        interpolate_by_three         = 3'b010,
        interpolate_by_twelve        = 3'b011,
        interpolate_by_twentyfour    = 3'b100,
        interpolate_by_fortyeight    = 3'b101
    } out_mode_t;

    // kind of the last decoded entry
    typedef enum logic [1:0] {
        KIND_DATA    = 2'b00,
        KIND_IDLE    = 2'b01,
        KIND_CONFIG  = 2'b10,
        KIND_INVALID = 2'b11
    } entry_kind_t;

    // playback request towards the segment reader
    typedef struct packed {
        logic [31:0]         start_addr;
        logic [31:0]         end_addr;
        logic                to_seg_end;
        logic [SEG_ID_W-1:0] segment_id;
    } play_req_t;

    // idle output values
    typedef struct packed {
        logic [31:0] sample;
        logic [14:0] i_value;
        logic [14:0] q_value;
        logic [13:0] dac_value;
    } idle_out_t;

endpackage : seq_entry_pkg

// ==== sequence_entry_decoder.sv ====
/*
 * sequence entry decoder: apb registers hold one six-word entry, a submit
 * decodes it into data playback, configuration or idle pause, and dynamic
 * selection comes from the host or the external control port.
 * assumes apb master on clk; external select pins are asynchronous.
 */
// Our own choices: the address map and the APB register port.
// How it works
// - start word is first sample played
// - end word is last sample played
// - all-ones end plays to segment end
// - code zero idles, code one configures
// - upper code half is action table id
// - idle pause drives idle sample word
// - interpolated idle i 14:0, q 30:16
// - precision uses 13:0, speed uses 11:0
// - idle delay counted in mode units, minimum
// - sixth word of idle entry ignored
// - ext-off matters only in dynamic mode
// - ext off: host selection only
// - ext on: host or external port
// - ext-off bit writable and readable
// - control bit 31 splits data/command
// - six words in fixed order
`timescale 1ns/100ps
module sequence_entry_decoder (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // external dynamic control port
    input  wire logic                           ext_sel_valid,
    input  wire logic [18:0]                    ext_sel_index,
    // decoded actions
    output seq_entry_pkg::play_req_t            play_req,
    output logic                                play_go,
    output logic                                config_go,
    output logic      [15:0]                    action_id,
    output logic                                idle_active,
    output seq_entry_pkg::idle_out_t            idle_out,
    output logic                                dyn_sel_go,
    output logic      [18:0]                    dyn_sel_index
);
    import seq_entry_pkg::*;

    logic [31:0]   word_reg [NUM_WORDS];  // entry words in fixed order
    logic [31:0]   ctrl_reg;              // mode, dynamic, ext-off
    logic [31:0]   prdata_reg;            // read data latched in setup
    logic          invalid_reg;           // sticky invalid code flag
    entry_kind_t   kind_reg;              // last decoded kind
    logic [31:0]   remain_reg;            // idle granules left
    logic [5:0]    presc_reg;             // clocks within one granule
    logic [18:0]   sel_now_reg;           // last accepted selection
    logic [2:0]    ext_v_sync;            // three-stage valid sync
    logic [18:0]   ext_i_s1;              // index sync stages
    logic [18:0]   ext_i_s2;
    logic [18:0]   ext_i_s3;
    logic          ext_level_reg;         // agreed external valid level
    logic          ext_rise_reg;          // one-cycle external request
    logic [18:0]   ext_index_reg;         // index captured with agreement

    // bus phases, control fields and entry decode
    logic          acc;
    logic          wr;
    logic          mapped;
    logic          submit;
    logic          host_sel;
    out_mode_t     mode;
    logic          dyn_on;
    logic          ext_off;
    logic [5:0]    mult;
    logic [31:0]   min_delay;
    logic [31:0]   word0;
    logic [31:0]   word2;
    logic          is_cmd;

    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign mapped   = (paddr <= OFS_REMAIN) && (paddr[1:0] == 2'b00);
    assign pready   = acc;                // one wait-free access after setup
    assign pslverr  = acc & ~mapped;
    assign prdata   = prdata_reg;
    assign submit   = wr & (paddr == OFS_CTRL) & pwdata[CTRL_SUBMIT_BIT];
    assign host_sel = wr & (paddr == OFS_HOST_SEL);
    assign mode     = out_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
    assign dyn_on   = ctrl_reg[CTRL_DYN_BIT];
    assign ext_off  = ctrl_reg[CTRL_EXTOFF_BIT];
    assign word0    = word_reg[0];
    assign word2    = word_reg[2];
    assign is_cmd   = word0[CMD_FLAG_BIT];  // data or command

    // delay unit and minimum per output mode
    always_comb begin
        case (mode)
            direct_high_speed_output: begin
                mult      = 6'd1;
                min_delay = MIN_SPEED;
            end
            direct_high_precision_output: begin
                mult      = 6'd1;
                min_delay = MIN_PRECISION;
            end
            interpolate_by_three: begin
                mult      = 6'd3;
                min_delay = MIN_INTERP;
            end
            interpolate_by_twelve: begin
                mult      = 6'd12;
                min_delay = MIN_INTERP;
            end
            interpolate_by_twentyfour: begin
                mult      = 6'd24;
                min_delay = MIN_INTERP;
            end
            interpolate_by_fortyeight: begin
                mult      = 6'd48;
                min_delay = MIN_INTERP;
            end
            default: begin
                // unused codes behave as the fastest direct mode
                mult      = 6'd1;
                min_delay = MIN_SPEED;
            end
        endcase
    end

    // entry word storage, one register per word
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
            always_ff @(posedge clk) begin
                if (srst) begin
                    word_reg[gi] <= 32'h0000_0000;
                end else if (wr && paddr == OFS_WORD0 + 8'(gi * 4)) begin
                    word_reg[gi] <= pwdata;
                end
            end
        end
    endgenerate

    // control register; submit bit is a strobe and never stored
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl_reg <= {26'h0, pwdata[5:1], 1'b0};  // ext-off is plain r/w
        end
    end

    // read data is latched in the setup cycle so it comes from a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14:
                    prdata_reg <= word_reg[paddr[4:2]];
                OFS_CTRL:     prdata_reg <= ctrl_reg;  // ext-off reads back
                OFS_STATUS:   prdata_reg <= {28'h0, kind_reg, invalid_reg, idle_active};
                OFS_SEL_NOW:  prdata_reg <= {13'h0, sel_now_reg};
                OFS_REMAIN:   prdata_reg <= remain_reg;
                default:      prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // entry decode on submit; a submit during a pause is ignored
    always_ff @(posedge clk) begin
        if (srst) begin
            play_req  <= '0;
            play_go   <= 1'b0;
            config_go <= 1'b0;
            action_id <= 16'h0000;
            kind_reg  <= KIND_DATA;
        end else begin
            play_go   <= 1'b0;
            config_go <= 1'b0;
            if (submit && !idle_active) begin
                if (!is_cmd) begin
                    // data entry: offsets bound the played part
                    play_req.start_addr <= word_reg[4];
                    play_req.end_addr   <= word_reg[5];
                    play_req.to_seg_end <= (word_reg[5] == END_TO_SEGEND);
                    play_req.segment_id <= word_reg[3][SEG_ID_W-1:0];
                    play_go             <= 1'b1;
                    kind_reg            <= KIND_DATA;
                end else if (word2[15:0] == CODE_CONFIG) begin
                    // configuration entry
                    play_req.start_addr <= word_reg[4];
                    play_req.end_addr   <= word_reg[5];
                    play_req.to_seg_end <= (word_reg[5] == END_TO_SEGEND);
                    play_req.segment_id <= word_reg[3][SEG_ID_W-1:0];
                    action_id           <= word2[31:16];
                    config_go           <= 1'b1;
                    kind_reg            <= KIND_CONFIG;
                end else if (word2[15:0] == CODE_IDLE) begin
                    kind_reg <= KIND_IDLE;  // action id not taken here
                end else begin
                    kind_reg <= KIND_INVALID;  // no action started
                end
            end
        end
    end

    // sticky invalid flag, write 1 to clear, a new event wins
    always_ff @(posedge clk) begin
        if (srst) begin
            invalid_reg <= 1'b0;
        end else if (submit && !idle_active && is_cmd
                     && word2[15:0] != CODE_IDLE && word2[15:0] != CODE_CONFIG) begin
            invalid_reg <= 1'b1;
        end else if (wr && paddr == OFS_STATUS && pwdata[STAT_INVALID_BIT]) begin
            invalid_reg <= 1'b0;
        end
    end

    // idle pause: granule counter and prescaler
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_active <= 1'b0;
            remain_reg  <= 32'h0000_0000;
            presc_reg   <= 6'h00;
        end else if (!idle_active) begin
            if (submit && is_cmd && word2[15:0] == CODE_IDLE) begin
                idle_active <= 1'b1;
                // short delays are raised to the mode minimum
                remain_reg  <= (word_reg[4] < min_delay) ? min_delay : word_reg[4];
                presc_reg   <= mult - 6'd1;
            end
        end else if (presc_reg != 6'h00) begin
            presc_reg <= presc_reg - 6'd1;
        end else begin
            presc_reg <= mult - 6'd1;
            if (remain_reg == 32'h0000_0001) begin
                idle_active <= 1'b0;
            end
            remain_reg <= remain_reg - 32'h0000_0001;
        end
    end

    // idle sample fields, latched at idle start; word 5 never read
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_out <= '0;
        end else if (!idle_active && submit && is_cmd && word2[15:0] == CODE_IDLE) begin
            idle_out.sample  <= word_reg[3];  // held through the pause
            idle_out.i_value <= word_reg[3][14:0];
            idle_out.q_value <= word_reg[3][30:16];
            if (mode == direct_high_precision_output) begin
                idle_out.dac_value <= word_reg[3][13:0];
            end else begin
                idle_out.dac_value <= {2'b00, word_reg[3][11:0]};
            end
        end
    end

    // external port: three flops, counted once stages two and three agree
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_v_sync    <= 3'b000;
            ext_i_s1      <= 19'h00000;
            ext_i_s2      <= 19'h00000;
            ext_i_s3      <= 19'h00000;
            ext_level_reg <= 1'b0;
            ext_rise_reg  <= 1'b0;
            ext_index_reg <= 19'h00000;
        end else begin
            ext_v_sync    <= {ext_v_sync[1:0], ext_sel_valid};
            ext_i_s1      <= ext_sel_index;
            ext_i_s2      <= ext_i_s1;
            ext_i_s3      <= ext_i_s2;
            ext_rise_reg  <= 1'b0;
            if (ext_v_sync[1] == ext_v_sync[2]) begin
                ext_level_reg <= ext_v_sync[2];
                if (ext_v_sync[2] && !ext_level_reg && ext_i_s2 == ext_i_s3) begin
                    ext_rise_reg  <= 1'b1;
                    ext_index_reg <= ext_i_s3;
                end
            end
        end
    end

    // dynamic selection source; host wins a same-cycle tie
    always_ff @(posedge clk) begin
        if (srst) begin
            dyn_sel_go    <= 1'b0;
            dyn_sel_index <= 19'h00000;
            sel_now_reg   <= 19'h00000;
        end else begin
            dyn_sel_go <= 1'b0;
            if (dyn_on && host_sel) begin  // host allowed whatever ext-off says
                dyn_sel_go    <= 1'b1;
                dyn_sel_index <= pwdata[18:0];
                sel_now_reg   <= pwdata[18:0];
            end else if (dyn_on && !ext_off && ext_rise_reg) begin
                dyn_sel_go    <= 1'b1;
                dyn_sel_index <= ext_index_reg;
                sel_now_reg   <= ext_index_reg;
            end
        end
    end

    // checks
    AST_START_ADDR: assert property (@(posedge clk) disable iff (srst)
        (submit && !idle_active && !is_cmd) |=> play_go && play_req.start_addr == $past(word_reg[4]))
        else $error("start offset not passed to playback");
    AST_END_ADDR: assert property (@(posedge clk) disable iff (srst)
        play_go |-> play_req.end_addr == $past(word_reg[5]))
        else $error("end offset not passed to playback");
    AST_SEG_END: assert property (@(posedge clk) disable iff (srst)
        (play_go || config_go) |-> play_req.to_seg_end == (play_req.end_addr == END_TO_SEGEND))
        else $error("all-ones end offset not flagged");
    AST_CONFIG: assert property (@(posedge clk) disable iff (srst)
        config_go |-> action_id == $past(word2[31:16]) && $past(word2[15:0]) == CODE_CONFIG)
        else $error("configuration action id wrong");
    AST_IDLE_START: assert property (@(posedge clk) disable iff (srst)
        (submit && !idle_active && is_cmd && word2[15:0] == CODE_IDLE) |=> idle_active[*2])
        else $error("idle pause did not start");
    AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (srst)
        (idle_active && $past(idle_active)) |-> $stable(idle_out.sample))
        else $error("idle sample changed during pause");
    AST_IQ: assert property (@(posedge clk) disable iff (srst)
        idle_active |-> idle_out.q_value == idle_out.sample[30:16])
        else $error("quadrature idle value misplaced");
    AST_MIN: assert property (@(posedge clk) disable iff (srst)
        $rose(idle_active) |-> remain_reg >= min_delay)
        else $error("idle delay below minimum");
    AST_INVALID: assert property (@(posedge clk) disable iff (srst)
        (kind_reg == KIND_INVALID && $changed(kind_reg)) |-> !idle_active && !config_go && !play_go)
        else $error("invalid code started an action");
    AST_EXT_OFF: assert property (@(posedge clk) disable iff (srst)
        (dyn_sel_go && $past(ext_off)) |-> $past(host_sel))
        else $error("external selection taken while disabled");
    AST_DYN_ONLY: assert property (@(posedge clk) disable iff (srst)
        dyn_sel_go |-> $past(dyn_on))
        else $error("selection outside dynamic mode");

endmodule : sequence_entry_decoder

// ==== sequence_entry_decoder_test.sv ====
/*
 * self-checking bench of the sequence entry decoder.
 * assumes zero-wait apb answers and the register layout of the package.
 */
`timescale 1ns/100ps
module sequence_entry_decoder_test;
    import seq_entry_pkg::*;
    logic        clk = 1'b0;           // 200 MHz
    logic        srst = 1'b1;          // held six cycles
    logic        psel = 1'b0;          // apb request
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_sel_valid;        // from the port model
    logic [18:0] ext_sel_index;
    logic        fire = 1'b0;          // starts a port request
    logic [18:0] ext_idx = 19'h0;
    play_req_t   play_req;
    logic        play_go;
    logic        config_go;
    logic [15:0] action_id;
    logic        idle_active;
    idle_out_t   idle_out;
    logic        dyn_sel_go;
    logic [18:0] dyn_sel_index;
    logic [31:0] words [6];            // entry under test
    logic [31:0] rdat;                 // last read data
    logic        slverr;               // last error answer
    logic [31:0] r;
    logic [15:0] lfsr = 16'hED9F;      // fixed seed
    int          err_count = 0;
    int          checks = 0;
    int          go_cnt = 0;           // selection pulses seen
    int          n;

    // free-running clock
    always #2.5 clk = ~clk;

    // count selection pulses; each must be one cycle wide
    always @(posedge clk) if (dyn_sel_go === 1'b1) go_cnt <= go_cnt + 1;

    sequence_entry_decoder i_sequence_entry_decoder (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_sel_valid(ext_sel_valid), .ext_sel_index(ext_sel_index),
        .play_req(play_req), .play_go(play_go), .config_go(config_go),
        .action_id(action_id), .idle_active(idle_active), .idle_out(idle_out),
        .dyn_sel_go(dyn_sel_go), .dyn_sel_index(dyn_sel_index));

    ext_port_model i_ext_port_model (.clk(clk), .fire(fire), .idx(ext_idx),
        .ext_sel_valid(ext_sel_valid), .ext_sel_index(ext_sel_index));

    // random words from the feedback register
    function automatic logic [31:0] rnd();
        for (int k = 0; k < 32; k++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            rnd[k] = lfsr[0];
        end
    endfunction : rnd

    // expected idle length in clocks: delay raised to minimum, times unit
    function automatic int idle_len(input int m, input logic [31:0] d);
        logic [31:0] mn;
        mn = (m == 0) ? MIN_SPEED : (m == 1) ? MIN_PRECISION : MIN_INTERP;
        if (d < mn) d = mn;
        return int'(d) * ((m < 2) ? 1 : (m == 2) ? 3 : (m == 3) ? 12 : (m == 4) ? 24 : 48);
    endfunction : idle_len

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) err_count++;
        rdat    = prdata;
        slverr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // load six words in order, set the mode, then submit
    task automatic submit(input logic [31:0] ctrl);
        for (int k = 0; k < NUM_WORDS; k++) apb(1'b1, OFS_WORD0 + 8'(4 * k), words[k]);
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b1, OFS_CTRL, ctrl | 32'h0000_0001);
        @(negedge clk);
    endtask : submit

    task automatic conclude();
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // watchdog: the run needs about 22500 cycles
    initial begin
        #300000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        // data entries, the first running to segment end
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < 6; k++) words[k] = rnd();
            words[0][31] = 1'b0;
            words[4][5:0] = 6'h00;
            words[5][5:0] = 6'h00;
            if (t == 0) words[5] = END_TO_SEGEND;
            submit(32'h0);
            chk(play_go, 1'b1);
            chk(play_req.start_addr, words[4]);
            chk(play_req.end_addr, words[5]);
            chk(play_req.to_seg_end, t == 0);
            chk(play_req.segment_id, words[3][18:0]);
            @(negedge clk);
            chk(play_go, 1'b0);
        end
        // configuration entry with a random action table id
        r = rnd();
        words[0] = 32'h8000_0000;
        words[2] = {r[31:16], CODE_CONFIG};
        submit(32'h0);
        chk({config_go, play_go, idle_active}, 3'b100);
        chk(action_id, r[31:16]);
        chk(play_req.start_addr, words[4]);
        chk(play_req.end_addr, words[5]);
        // idle pause in every output mode, speed mode above minimum, the others below
        for (int m = 0; m < 6; m++) begin
            r = rnd();
            words[2] = {r[31:16], CODE_IDLE};
            words[3] = rnd();
            words[4] = (m == 0) ? 32'd700 : 32'd5;
            words[5] = rnd();
            submit(32'(m) << CTRL_MODE_LSB);
            chk({idle_active, config_go}, 2'b10);
            chk(idle_out.sample, words[3]);
            if (m == 0) chk(idle_out.dac_value, {2'b00, words[3][11:0]});
            if (m == 1) chk(idle_out.dac_value, words[3][13:0]);
            if (m > 1) chk({idle_out.i_value, idle_out.q_value}, {words[3][14:0], words[3][30:16]});
            n = 0;
            while (idle_active === 1'b1 && n < 20000) begin
                n++;
                @(negedge clk);
            end
            chk(n, idle_len(m, words[4]));
        end
        // unknown command code: nothing starts, status flags it
        r = rnd();
        words[2] = {16'h0000, r[15:0] | 16'h0002};
        submit(32'h0);
        chk({play_go, config_go, idle_active}, 3'b000);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdat[3:1], 3'b111);
        // disable bit written both ways and read back
        for (int v = 1; v >= 0; v--) begin
            apb(1'b1, OFS_CTRL, 32'(v) << CTRL_EXTOFF_BIT);
            apb(1'b0, OFS_CTRL, 32'h0);
            chk(rdat[CTRL_EXTOFF_BIT], v[0]);
        end
        // host and port selection under every dynamic / disable pairing
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_CTRL, 32'(c) << CTRL_DYN_BIT);
            r = rnd();
            go_cnt = 0;
            apb(1'b1, OFS_HOST_SEL, {13'h0, r[18:0]});
            repeat (3) @(negedge clk);
            chk(go_cnt, c % 2);
            if (c % 2 == 1) chk(dyn_sel_index, r[18:0]);
            go_cnt = 0;
            @(posedge clk);
            fire    <= 1'b1;
            ext_idx <= r[18:0] ^ 19'h5A5A5;
            @(posedge clk);
            fire    <= 1'b0;
            repeat (20) @(posedge clk);
            chk(go_cnt, c == 1);
            if (c == 1) chk(dyn_sel_index, r[18:0] ^ 19'h5A5A5);
        end
        // last accepted selection is the host command of the final pairing
        apb(1'b0, OFS_SEL_NOW, 32'h0);
        chk(rdat, {13'h0, r[18:0]});
        // unmapped address answers with an error and reads zero
        apb(1'b0, 8'h2C, 32'h0);
        chk({slverr, rdat}, {1'b1, 32'h0});
        conclude();
    end
endmodule : sequence_entry_decoder_test
